/* common/fdr_defines.vh */
// register map, field positions, reset values and ramp timing for the fan duty ramp block
// Function
// [R1] remote 2 ramp field limits duty change rate
// [R2] fast table: codes 000-011 give 37.5..7.5 s
// [R3] fast table: codes 100-111 step 8,12,24,48
// [R4] slow table: steps 1,2,3,4,8,12,24,48
// [R5] bit 7 enables remote 2 smoothing
// [R6] lock makes ramp register read-only
// [R7] three floor duty registers, reset 0x80
// [R8] floor duty scales linearly, 0xFF full
// [R9] automatic mode makes floor registers read-only
// [R10] step toward target per slot, no overshoot
`ifndef FDR_DEFINES_VH
`define FDR_DEFINES_VH

// register indexes; byte address is four times the index
`define FDR_IDX_FLOOR1      8'h64
`define FDR_IDX_FLOOR2      8'h65
`define FDR_IDX_FLOOR3      8'h66
`define FDR_IDX_RAMP        8'h62
`define FDR_IDX_STATUS      8'h61
`define FDR_IDX_W           8

// reset values
`define FDR_FLOOR_RST       8'h80
`define FDR_RAMP_RST        4'h0

// ramp register fields
`define FDR_RAMP_EN_BIT     7
`define FDR_RAMP_CODE_HI    6
`define FDR_RAMP_CODE_LO    4

// status register fields
`define FDR_STAT_ACTIVE_BIT 8

// full-scale ramp times at one-count increments, in milliseconds
`define FDR_FAST_FULL_MS    37500
`define FDR_SLOW_FULL_MS    52200
`define FDR_CLK_MHZ         200
`define FDR_FULL_STEPS      255

// pwm frame: 255 counts so that 0xFF gives a constant high level
`define FDR_PWM_LAST        8'hFE
`define FDR_DUTY_FULL       8'hFF

`endif

/* design/fdr_pwm_out.v */
// pwm generator for the remote 2 fan drive output
`timescale 1ns/1ps
`include "fdr_defines.vh"

module fdr_pwm_out (
	// clock and reset
	input  wire       pclk,
	input  wire       presetn,
	// duty in, drive out
	input  wire [7:0] duty,
	output reg        pwm_out
);

	reg [7:0] cnt_reg;

	// free-running frame counter, 255 counts per frame
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= 8'h00;
		end else if (cnt_reg == `FDR_PWM_LAST) begin
			cnt_reg <= 8'h00;
		end else begin
			cnt_reg <= cnt_reg + 8'h01;
		end
	end

	// high for duty counts of 255; 0x00 stays low, 0xFF stays high
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwm_out <= 1'b0;
		end else begin
			pwm_out <= (cnt_reg < duty); // [R8]
		end
	end

endmodule // fdr_pwm_out

/* design/fdr_top.v */
// fan duty ramp and floor duty registers behind an apb slave
`timescale 1ns/1ps
`include "fdr_defines.vh"

module fdr_top #(
	parameter FAST_SLOT_CYC = ((`FDR_FAST_FULL_MS * 1000) / `FDR_FULL_STEPS) * `FDR_CLK_MHZ,
	parameter SLOW_SLOT_CYC = ((`FDR_SLOW_FULL_MS * 1000) / `FDR_FULL_STEPS) * `FDR_CLK_MHZ,
	parameter SLOT_W        = 27
) (
	// apb slave
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// settings held elsewhere in the controller, same clock
	input  wire        cfg_lock,
	input  wire        cfg_slow_table,
	input  wire        auto_mode,
	input  wire [7:0]  remote2_target_duty,
	// outputs to the fan drive
	output reg  [7:0]  floor_duty_1,
	output reg  [7:0]  floor_duty_2,
	output reg  [7:0]  floor_duty_3,
	output reg  [7:0]  remote2_duty,
	output wire        fan_drive_output
);

	reg  [3:0]        ramp_reg;
	reg  [7:0]        duty_reg;
	reg  [SLOT_W-1:0] slot_cnt_reg;
	reg  [SLOT_W-1:0] slot_last;
	reg  [7:0]        duty_next;
	reg  [31:0]       rdata_next;
	reg               err_next;
	wire [`FDR_IDX_W-1:0] idx;
	wire              setup;
	wire              wr_done;
	wire              mapped;
	wire              slot_tick;
	wire              smooth_en;
	wire [2:0]        rate_code;
	wire [7:0]        step;

	// slot increment per ramp code; fast code 3 steps by 5 so full scale takes 7.5 s
	function [7:0] step_of;
		input [2:0] code;
		input       slow;
		begin
			case (code)
				3'h0:    step_of = 8'h01;
				3'h1:    step_of = 8'h02;
				3'h2:    step_of = 8'h03;
				3'h3:    step_of = slow ? 8'h04 : 8'h05;
				3'h4:    step_of = 8'h08;
				3'h5:    step_of = 8'h0C;
				3'h6:    step_of = 8'h18;
				default: step_of = 8'h30;
			endcase
		end
	endfunction

	// register index of a byte address; upper bits must be clear
	function is_reg;
		input [11:0] addr;
		input [7:0]  want;
		begin
			is_reg = (addr[1:0] == 2'b00) && (addr[11:2] == {2'b00, want});
		end
	endfunction

	// apb decode
	assign idx     = paddr[9:2];
	assign setup   = psel & ~penable;
	assign wr_done = psel & penable & pready & pwrite;
	assign mapped  = is_reg(paddr, `FDR_IDX_FLOOR1) | is_reg(paddr, `FDR_IDX_FLOOR2) |
	                 is_reg(paddr, `FDR_IDX_FLOOR3) | is_reg(paddr, `FDR_IDX_RAMP) |
	                 is_reg(paddr, `FDR_IDX_STATUS);

	// read mux, sampled in the setup cycle so prdata leaves a flip-flop
	always @* begin
		rdata_next = 32'h0000_0000;
		err_next   = ~mapped;
		if (mapped) begin
			case (idx)
				`FDR_IDX_FLOOR1: rdata_next[7:0] = floor_duty_1;
				`FDR_IDX_FLOOR2: rdata_next[7:0] = floor_duty_2;
				`FDR_IDX_FLOOR3: rdata_next[7:0] = floor_duty_3;
				`FDR_IDX_RAMP:   rdata_next[7:4] = ramp_reg;
				`FDR_IDX_STATUS: begin
					rdata_next[7:0]                  = duty_reg;
					rdata_next[`FDR_STAT_ACTIVE_BIT] = (duty_reg != remote2_target_duty);
				end
				default:         rdata_next = 32'h0000_0000;
			endcase
		end
	end

	// no wait state: answer in the first access cycle, so an access takes the minimum two cycles
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= setup;
			pslverr <= setup & err_next;
			prdata  <= (setup & ~pwrite) ? rdata_next : 32'h0000_0000;
		end
	end

	// floor duty registers; automatic mode drops writes silently
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			floor_duty_1 <= `FDR_FLOOR_RST; // [R7]
			floor_duty_2 <= `FDR_FLOOR_RST; // [R7]
			floor_duty_3 <= `FDR_FLOOR_RST; // [R7]
		end else if (wr_done && !auto_mode) begin // [R9]
			if (is_reg(paddr, `FDR_IDX_FLOOR1)) begin
				floor_duty_1 <= pwdata[7:0]; // [R8]
			end
			if (is_reg(paddr, `FDR_IDX_FLOOR2)) begin
				floor_duty_2 <= pwdata[7:0]; // [R8]
			end
			if (is_reg(paddr, `FDR_IDX_FLOOR3)) begin
				floor_duty_3 <= pwdata[7:0]; // [R8]
			end
		end
	end

	// ramp and smoothing register; lock turns it read-only
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ramp_reg <= `FDR_RAMP_RST;
		end else if (wr_done && !cfg_lock && is_reg(paddr, `FDR_IDX_RAMP)) begin // [R6]
			ramp_reg <= pwdata[`FDR_RAMP_EN_BIT:`FDR_RAMP_CODE_LO]; // [R5]
		end
	end

	assign smooth_en = ramp_reg[3]; // [R5]
	assign rate_code = ramp_reg[2:0]; // [R1]
	assign step      = step_of(rate_code, cfg_slow_table); // [R2] [R3] [R4]

	// slot length follows the table select bit
	always @* begin
		if (cfg_slow_table) begin
			slot_last = SLOW_SLOT_CYC[SLOT_W-1:0] - {{(SLOT_W-1){1'b0}}, 1'b1}; // [R4]
		end else begin
			slot_last = FAST_SLOT_CYC[SLOT_W-1:0] - {{(SLOT_W-1){1'b0}}, 1'b1}; // [R2]
		end
	end

	// slot timer; a table switch mid-slot shortens the slot at worst
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slot_cnt_reg <= {SLOT_W{1'b0}};
		end else if (slot_cnt_reg >= slot_last) begin
			slot_cnt_reg <= {SLOT_W{1'b0}};
		end else begin
			slot_cnt_reg <= slot_cnt_reg + {{(SLOT_W-1){1'b0}}, 1'b1};
		end
	end

	assign slot_tick = (slot_cnt_reg >= slot_last);

	// duty walks toward target by one step per slot, clamped at target
	always @* begin
		duty_next = duty_reg;
		if (!smooth_en) begin
			duty_next = remote2_target_duty; // [R5]
		end else if (slot_tick) begin
			if (remote2_target_duty > duty_reg) begin
				if (remote2_target_duty - duty_reg <= step) begin
					duty_next = remote2_target_duty; // [R10]
				end else begin
					duty_next = duty_reg + step; // [R1] [R10]
				end
			end else if (remote2_target_duty < duty_reg) begin
				if (duty_reg - remote2_target_duty <= step) begin
					duty_next = remote2_target_duty; // [R10]
				end else begin
					duty_next = duty_reg - step; // [R1] [R10]
				end
			end
		end
	end

	// current duty state and its registered copy for the output port
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			duty_reg     <= 8'h00;
			remote2_duty <= 8'h00;
		end else begin
			duty_reg     <= duty_next;
			remote2_duty <= duty_next;
		end
	end

	// fan drive pin, registered inside the generator
	fdr_pwm_out u_pwm (
		.pclk    (pclk),
		.presetn (presetn),
		.duty    (duty_reg),
		.pwm_out (fan_drive_output)
	);

endmodule // fdr_top

/* tb/fdr_chk.sv */
// port-level assertions for the fan duty ramp block
`timescale 1ns/1ps
module fdr_chk (
	// apb
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	// control and duty
	input wire logic        auto_mode,
	input wire logic [7:0]  remote2_target_duty,
	input wire logic [7:0]  remote2_duty,
	input wire logic [7:0]  floor_duty_1,
	input wire logic [7:0]  floor_duty_2,
	input wire logic [7:0]  floor_duty_3
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// the two phases of a transfer
	sequence s_setup; psel && !penable; endsequence
	sequence s_acc; psel && penable && pready; endsequence
	property p_ans; s_setup |=> pready; endproperty
	a_ans: assert property (p_ans) else $error("no answer after setup");
	property p_err; pslverr |-> pready; endproperty
	a_err: assert property (p_err) else $error("error outside answer");
	property p_idle; !pready |-> prdata == 32'h0; endproperty
	a_idle: assert property (p_idle) else $error("read data outside answer");
	property p_rst; $rose(presetn) |-> {floor_duty_1, floor_duty_2, floor_duty_3} == 24'h808080;
	endproperty
	a_rst: assert property (p_rst) else $error("floor reset value wrong");
	property p_rd; s_setup ##0 (!pwrite && paddr == 12'h190) |=> prdata == {24'h0, floor_duty_1};
	endproperty
	a_rd: assert property (p_rd) else $error("floor read wrong");
	property p_wr; s_acc ##0 (pwrite && !auto_mode && paddr == 12'h194) |=>
		floor_duty_2 == 8'($past(pwdata)); endproperty
	a_wr: assert property (p_wr) else $error("floor write lost");
	property p_auto; s_acc ##0 (pwrite && auto_mode) |=>
		$stable({floor_duty_1, floor_duty_2, floor_duty_3}); endproperty
	a_auto: assert property (p_auto) else $error("floor written in auto mode");
	// a slot step may reach the target but never pass it
	property p_up; remote2_duty < remote2_target_duty |=> remote2_duty <= $past(remote2_target_duty);
	endproperty
	a_up: assert property (p_up) else $error("duty overshoot upward");
	property p_dn; remote2_duty > remote2_target_duty |=> remote2_duty >= $past(remote2_target_duty);
	endproperty
	a_dn: assert property (p_dn) else $error("duty overshoot downward");
endmodule // fdr_chk

/* tb/fdr_fan_model.sv */
// fan stand-in: measures drive high time over each 255-cycle window
`timescale 1ns/1ps
module fdr_fan_model (
	// clock and drive in
	input  wire logic pclk,
	input  wire logic drive,
	// measured duty
	output logic [7:0] duty_seen
);
	int hi = 0, n = 0;
	// window equals the drive frame, so frame alignment does not matter
	always @(posedge pclk) begin
		hi = hi + drive;
		n = n + 1;
		if (n == 255) begin
			duty_seen <= hi[7:0];
			hi = 0;
			n = 0;
		end
	end
endmodule // fdr_fan_model

/* tb/testbench.sv */
// self-checking bench for the fan duty ramp block
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
	$display("unexpected %s exp %0h got %0h", n, e, g); end end
module testbench;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
	logic        cfg_lock = 0, cfg_slow_table = 0, auto_mode = 0, fan_drive_output;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [7:0]  remote2_target_duty = 0, floor_duty_1, floor_duty_2, floor_duty_3, remote2_duty;
	logic [7:0]  seen, d, lv[5] = '{8'h00, 8'h40, 8'h80, 8'hFF, 8'h00};
	int          fail_count = 0, cmp_count = 0, flr[3], w, k2, stp[8] = '{1, 2, 3, 4, 8, 12, 24, 48};
	int          fst[8] = '{1, 2, 3, 5, 8, 12, 24, 48}, sl, e1;
	always #2.5 pclk = ~pclk;
	// short slots keep the ramps to a few hundred cycles
	fdr_top #(.FAST_SLOT_CYC(20), .SLOW_SLOT_CYC(30)) dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cfg_lock(cfg_lock), .cfg_slow_table(cfg_slow_table), .auto_mode(auto_mode),
		.remote2_target_duty(remote2_target_duty), .floor_duty_1(floor_duty_1),
		.floor_duty_2(floor_duty_2), .floor_duty_3(floor_duty_3),
		.remote2_duty(remote2_duty), .fan_drive_output(fan_drive_output)
	);
	fdr_fan_model fan_u (.pclk(pclk), .drive(fan_drive_output), .duty_seen(seen));
	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] v);
		int t = 0;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, v};
		@(posedge pclk);
		penable <= 1;
		do begin @(posedge pclk); t++; end while (pready !== 1'b1 && t < 20);
		{rd, er} = {prdata, pslverr};
		if (t >= 20) fail_count++;
		{psel, penable} <= 2'b00;
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] e);
		apb(0, a, 0);
		`CHK("prdata", e, rd)
	endtask
	// wait for the next duty step; w ends as the gap in cycles
	task automatic wt;
		d = remote2_duty;
		w = 0;
		do begin @(posedge pclk); w++; end while (remote2_duty === d && w < 99);
	endtask
	task automatic final_report;
		if (fail_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		void'($urandom(32'h73BA));
		flr = '{128, 128, 128};
		repeat (6) @(posedge pclk);
		presetn <= 1;
		for (int i = 0; i < 3; i++) rchk(12'(12'h190 + 4 * i), 32'(flr[i]));
		rchk(12'h188, 0);
		// random floor writes, odd passes in automatic mode; first pass always floor 2
		for (int k = 0; k < 6; k++) begin
			k2 = (k == 0) ? 1 : $urandom_range(2);
			d = 8'($urandom);
			auto_mode <= k[0];
			apb(1, 12'(12'h190 + 4 * k2), {24'hFFFFFF, d});
			if (!k[0]) flr[k2] = d;
			rchk(12'(12'h190 + 4 * k2), 32'(flr[k2]));
			`CHK("floor", 8'(flr[k2]), 8'({floor_duty_3, floor_duty_2, floor_duty_1} >> (8 * k2)))
		end
		apb(0, 12'h3FC, 0);
		`CHK("pslverr", 1'b1, er)
		`CHK("prdata", 32'h0, rd)
		cfg_lock <= 1;
		apb(1, 12'h188, 32'hF0);
		rchk(12'h188, 0);
		cfg_lock <= 0;
		// every rate code, tables mixed so code 3 is seen on the fast table
		for (int c = 0; c < 8; c++) begin
			sl = c[0] ^ c[1];
			e1 = sl ? stp[c] : fst[c];
			remote2_target_duty <= 0;
			apb(1, 12'h188, 0);
			cfg_slow_table <= sl[0];
			apb(1, 12'h188, 32'h8F | (c << 4));
			rchk(12'h188, 32'h80 | (c << 4));
			remote2_target_duty <= 8'hFF;
			wt();
			`CHK("duty", 8'(e1), remote2_duty)
			wt();
			`CHK("slot", sl ? 30 : 20, w)
			`CHK("duty", 8'(2 * e1), remote2_duty)
			rchk(12'h184, 32'h100 | (2 * e1));
		end
		// smoothing off: drive measured at the fan follows the target
		apb(1, 12'h188, 0);
		lv[4] = 8'($urandom);
		for (int j = 0; j < 5; j++) begin
			remote2_target_duty <= lv[j];
			repeat (600) @(posedge pclk);
			`CHK("fan", lv[j], seen)
		end
		final_report();
	end
	initial begin
		#60000;
		fail_count++;
		final_report();
	end
endmodule // testbench
bind fdr_top fdr_chk chk_u (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.auto_mode(auto_mode), .remote2_target_duty(remote2_target_duty),
	.remote2_duty(remote2_duty), .floor_duty_1(floor_duty_1),
	.floor_duty_2(floor_duty_2), .floor_duty_3(floor_duty_3)
);
